// *** core/tamt_term_ctrl.sv ***
`timescale 1ns/1ns
module tamt_term_ctrl
    import tamt_pkg::*;
#(
    parameter int WRITE_LATENCY = WRITE_LATENCY_DEF,
    parameter int CMD_DELAY     = CMD_DELAY_DEF,
    parameter int REFRESH_CYC   = REFRESH_CYC_DEF,
    parameter int LOOP_EXIT     = LOOP_EXIT_DEF
) (
    input  wire logic CLK_IN,
    input  wire logic RST_N_IN,
    input  wire logic LINK_CLK_IN,
    input  wire logic TERM_CTRL_PIN_IN,
    input  wire logic CLK_ENABLE_PIN_IN,
    input  wire logic REFRESH_CMD_IN,
    input  wire logic LOOP_FREEZE_SELECT_BIT_IN,
    output logic      TERM_ON_OUT,
    output logic      ASYNC_MODE_OUT,
    output logic      TRANSITION_OUT,
    output logic      POWER_DOWN_OUT,
    output logic      LATE_EDGE_OUT
);

    // ****************************************************************
    // latency figures in link cycles
    // ****************************************************************
    // turn_on_latency and turn_off_latency, floored at one stage
    localparam int SYNC_LAT  = (WRITE_LATENCY > 2) ? WRITE_LATENCY - 2 : 1;
    // entry mode_change_window
    localparam int ENTRY_WIN = (WRITE_LATENCY > 1) ? WRITE_LATENCY - 1 : 1;
    // exit mode_change_window: max of turn-off and turn-on latencies
    localparam int EXIT_WIN  = SYNC_LAT;
    localparam logic [CNT_W-1:0] CMD_CNT   = CNT_W'(CMD_DELAY);
    localparam logic [CNT_W-1:0] RFC_CNT   = CNT_W'(REFRESH_CYC);
    localparam logic [CNT_W-1:0] EXIT_CNT  =
        CNT_W'((LOOP_EXIT > EXIT_WIN) ? LOOP_EXIT : EXIT_WIN);
    localparam logic [CNT_W-1:0] ENTRY_AGE = CNT_W'(ENTRY_WIN);

    // saturating decrement used by the command, refresh and exit counters
    function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
        dec_sat = (v == '0) ? v : v - 8'h01;
    endfunction : dec_sat

    // ****************************************************************
    // link domain reset release
    // ****************************************************************
    logic link_rst_meta;
    logic link_rst_n;

    // assert asynchronously, release on the link clock
    always_ff @(posedge LINK_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            link_rst_meta <= 1'b0;
            link_rst_n    <= 1'b0;
        end else begin
            link_rst_meta <= 1'b1;
            link_rst_n    <= link_rst_meta;
        end
    end

    // ****************************************************************
    // link domain: pin registration and sync pipeline
    // ****************************************************************
    logic                term_reg;
    logic                cke_reg;
    logic                cke_prev;
    logic                refresh_reg;
    logic                freeze_reg;
    logic [SYNC_LAT-1:0] sync_pipe;
    logic                next_term_reg;
    logic                next_cke_reg;
    logic                next_cke_prev;
    logic                next_refresh_reg;
    logic                next_freeze_reg;
    logic [SYNC_LAT-1:0] next_sync_pipe;

    // pins are launched on the link clock, so one register is registration
    always_comb begin
        next_term_reg    = TERM_CTRL_PIN_IN;
        next_cke_reg     = CLK_ENABLE_PIN_IN;
        next_cke_prev    = cke_reg;
        next_refresh_reg = REFRESH_CMD_IN;
        next_freeze_reg  = LOOP_FREEZE_SELECT_BIT_IN;
        // registered pin delayed by the latency, additive part included
        if (SYNC_LAT > 1) begin
            next_sync_pipe = {sync_pipe[SYNC_LAT-2:0], term_reg};
        end else begin
            next_sync_pipe = SYNC_LAT'(term_reg);
        end
    end

    always_ff @(posedge LINK_CLK_IN or negedge link_rst_n) begin
        if (!link_rst_n) begin
            term_reg    <= 1'b0;
            cke_reg     <= 1'b1;
            cke_prev    <= 1'b1;
            refresh_reg <= 1'b0;
            freeze_reg  <= 1'b1;
            sync_pipe   <= '0;
        end else begin
            term_reg    <= next_term_reg;
            cke_reg     <= next_cke_reg;
            cke_prev    <= next_cke_prev;
            refresh_reg <= next_refresh_reg;
            freeze_reg  <= next_freeze_reg;
            sync_pipe   <= next_sync_pipe;
        end
    end

    // ****************************************************************
    // link domain: mode state machine
    // ****************************************************************
    tamt_state_t      state;
    tamt_state_t      next_state;
    logic [CNT_W-1:0] cmd_cnt;
    logic [CNT_W-1:0] rfc_cnt;
    logic [CNT_W-1:0] exit_cnt;
    logic [CNT_W-1:0] edge_age;
    logic [CNT_W-1:0] next_cmd_cnt;
    logic [CNT_W-1:0] next_rfc_cnt;
    logic [CNT_W-1:0] next_exit_cnt;
    logic [CNT_W-1:0] next_edge_age;
    tamt_status_t     status;
    tamt_status_t     next_status;
    logic             cke_fall;
    logic             cke_rise;

    assign cke_fall = cke_prev & ~cke_reg;
    assign cke_rise = ~cke_prev & cke_reg;

    // counters stop and hold at zero, and the state moves one cycle after, so the end is included
    always_comb begin
        next_state    = state;
        next_cmd_cnt  = dec_sat(cmd_cnt);
        next_exit_cnt = dec_sat(exit_cnt);
        next_status   = status;
        // refresh time runs from every refresh, whatever the mode
        next_rfc_cnt  = refresh_reg ? RFC_CNT : dec_sat(rfc_cnt);
        // age of the last registered pin edge, saturating
        if (term_reg != sync_pipe[0]) begin
            next_edge_age = '0;
        end else if (edge_age != 8'hff) begin
            next_edge_age = edge_age + 8'h01;
        end else begin
            next_edge_age = edge_age;
        end
        case (state)
            TAMT_SYNC: begin
                // transitions only when the loop is frozen in power-down
                if (cke_fall && freeze_reg == LOOP_FROZEN) begin
                    next_state   = TAMT_ENTRY;
                    next_cmd_cnt = CMD_CNT;
                    // edge inside the entry window may answer either way
                    next_status.late_edge = (edge_age < ENTRY_AGE);
                end
            end
            TAMT_ENTRY: begin
                if (cke_rise) begin
                    // overlap: stays uncertain until the exit end
                    next_state    = TAMT_EXIT;
                    next_exit_cnt = EXIT_CNT;
                end else if (cmd_cnt == '0 && rfc_cnt == '0) begin
                    // later of command delay and refresh end, both inclusive
                    next_state = TAMT_POWER_DOWN;
                end
            end
            TAMT_POWER_DOWN: begin
                if (cke_rise) begin
                    next_state    = TAMT_EXIT;
                    next_exit_cnt = EXIT_CNT;
                end
            end
            TAMT_EXIT: begin
                if (cke_fall && freeze_reg == LOOP_FROZEN) begin
                    // short idle: uncertainty runs on into the entry period
                    next_state   = TAMT_ENTRY;
                    next_cmd_cnt = CMD_CNT;
                end else if (exit_cnt == '0) begin
                    next_state            = TAMT_SYNC;
                    next_status.late_edge = 1'b0;
                end
            end
            default: begin
                next_state = TAMT_SYNC;
            end
        endcase
        // async response through the whole entry-to-exit stretch
        next_status.use_async  = (next_state != TAMT_SYNC);
        next_status.transition = (next_state == TAMT_ENTRY) ||
                                 (next_state == TAMT_EXIT);
        next_status.power_down = ~cke_reg;
    end

    always_ff @(posedge LINK_CLK_IN or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state    <= TAMT_SYNC;
            cmd_cnt  <= '0;
            rfc_cnt  <= '0;
            exit_cnt <= '0;
            edge_age <= 8'hff;
            status   <= '0;
        end else begin
            state    <= next_state;
            cmd_cnt  <= next_cmd_cnt;
            rfc_cnt  <= next_rfc_cnt;
            exit_cnt <= next_exit_cnt;
            edge_age <= next_edge_age;
            status   <= next_status;
        end
    end

    // ****************************************************************
    // core domain: crossings
    // ****************************************************************
    logic         pin_meta;
    logic         pin_sync;
    logic         sync_meta;
    logic         sync_term;
    tamt_status_t stat_meta;
    tamt_status_t stat_sync;

    // every crossing is a level; the first stage feeds only the second
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pin_meta  <= 1'b0;
            pin_sync  <= 1'b0;
            sync_meta <= 1'b0;
            sync_term <= 1'b0;
            stat_meta <= '0;
            stat_sync <= '0;
        end else begin
            pin_meta  <= TERM_CTRL_PIN_IN;
            pin_sync  <= pin_meta;
            sync_meta <= sync_pipe[SYNC_LAT-1];
            sync_term <= sync_meta;
            stat_meta <= status;
            stat_sync <= stat_meta;
        end
    end

    // ****************************************************************
    // core domain: async delay and output select
    // ****************************************************************
    logic [CNT_W-1:0] async_cnt;
    logic             async_term;
    logic             term_on;
    logic [CNT_W-1:0] next_async_cnt;
    logic             next_async_term;
    logic             next_term_on;

    // the pin is applied directly; no latency pipeline on this path
    always_comb begin
        next_async_cnt  = async_cnt;
        next_async_term = async_term;
        if (pin_sync == async_term) begin
            next_async_cnt = '0;
        end else if (pin_sync) begin
            // turn-on: wait the least delay, never beyond the longest
            if (async_cnt + 8'h01 >= CNT_W'(ASYNC_ON_MIN_CYC) ||
                async_cnt + 8'h01 >= CNT_W'(ASYNC_ON_MAX_CYC)) begin
                next_async_term = 1'b1;
                next_async_cnt  = '0;
            end else begin
                next_async_cnt = async_cnt + 8'h01;
            end
        end else begin
            if (async_cnt + 8'h01 >= CNT_W'(ASYNC_OFF_MIN_CYC) ||
                async_cnt + 8'h01 >= CNT_W'(ASYNC_OFF_MAX_CYC)) begin
                next_async_term = 1'b0;
                next_async_cnt  = '0;
            end else begin
                next_async_cnt = async_cnt + 8'h01;
            end
        end
        // in a transition the async answer is one of the allowed two
        if (stat_sync.use_async) begin
            next_term_on = async_term;
        end else begin
            next_term_on = sync_term;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            async_cnt  <= '0;
            async_term <= 1'b0;
            term_on    <= 1'b0;
        end else begin
            async_cnt  <= next_async_cnt;
            async_term <= next_async_term;
            term_on    <= next_term_on;
        end
    end

    assign TERM_ON_OUT    = term_on;
    assign ASYNC_MODE_OUT = stat_sync.use_async;
    assign TRANSITION_OUT = stat_sync.transition;
    assign POWER_DOWN_OUT = stat_sync.power_down;
    assign LATE_EDGE_OUT  = stat_sync.late_edge;

endmodule : tamt_term_ctrl

// *** common/tamt_pkg.sv ***
package tamt_pkg;

    // ****************************************************************
    // clock and async delay figures
    // ****************************************************************
    localparam int CLK_PERIOD_PS      = 10000;
    localparam int ASYNC_ON_MIN_PS    = 2000;
    localparam int ASYNC_ON_MAX_PS    = 8500;
    localparam int ASYNC_OFF_MIN_PS   = 2000;
    localparam int ASYNC_OFF_MAX_PS   = 8500;

    // least times round up, longest times round down, never below one
    localparam int ASYNC_ON_MIN_CYC   =
        (ASYNC_ON_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ASYNC_OFF_MIN_CYC  =
        (ASYNC_OFF_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ASYNC_ON_MAX_CYC   =
        (ASYNC_ON_MAX_PS / CLK_PERIOD_PS < 1) ? 1
                                              : ASYNC_ON_MAX_PS / CLK_PERIOD_PS;
    localparam int ASYNC_OFF_MAX_CYC  =
        (ASYNC_OFF_MAX_PS / CLK_PERIOD_PS < 1) ? 1
                                               : ASYNC_OFF_MAX_PS / CLK_PERIOD_PS;

    // ****************************************************************
    // link-clock cycle defaults
    // ****************************************************************
    localparam int WRITE_LATENCY_DEF  = 5;
    localparam int CMD_DELAY_DEF      = 1;   // power_down_command_delay
    localparam int REFRESH_CYC_DEF    = 11;  // refresh_cycle_time
    localparam int LOOP_EXIT_DEF      = 10;  // locked_loop_exit_delay
    localparam int CNT_W              = 8;

    // value of loop_freeze_select_bit that freezes the loop in power-down
    localparam logic LOOP_FROZEN      = 1'b0;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        TAMT_SYNC,
        TAMT_ENTRY,
        TAMT_POWER_DOWN,
        TAMT_EXIT
    } tamt_state_t;

    typedef struct packed {
        logic use_async;
        logic transition;
        logic power_down;
        logic late_edge;
    } tamt_status_t;

endpackage : tamt_pkg

// *** dv/tamt_term_ctrl_properties.sv ***
`timescale 1ns/1ns
module tamt_term_ctrl_properties
    import tamt_pkg::*;
#(
    parameter int WRITE_LATENCY = WRITE_LATENCY_DEF,
    parameter int LOOP_EXIT     = LOOP_EXIT_DEF
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic LINK_CLK_IN,
    input wire logic TERM_CTRL_PIN_IN,
    input wire logic CLK_ENABLE_PIN_IN,
    input wire logic REFRESH_CMD_IN,
    input wire logic LOOP_FREEZE_SELECT_BIT_IN,
    input wire logic TERM_ON_OUT,
    input wire logic ASYNC_MODE_OUT,
    input wire logic TRANSITION_OUT,
    input wire logic POWER_DOWN_OUT,
    input wire logic LATE_EDGE_OUT
);
    // generous core-cycle bounds; the link pipeline has to fit inside them
    localparam int SYNC_MAX = 2 * WRITE_LATENCY + 4;
    localparam int EXIT_MAX = 2 * LOOP_EXIT + 10;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    // ****************************************************************
    // multi-step responses
    // ****************************************************************
    sequence s_sync_on;
        !TERM_ON_OUT [*4] ##[1:SYNC_MAX] TERM_ON_OUT;
    endsequence
    // a re-entry before the exit end keeps the async answer running on
    sequence s_exit_hold;
        ASYNC_MODE_OUT [*8] ##[1:EXIT_MAX]
            (!ASYNC_MODE_OUT || !CLK_ENABLE_PIN_IN);
    endsequence

    // ****************************************************************
    // checks
    // ****************************************************************
    a_async_on: assert property (
        $rose(TERM_CTRL_PIN_IN) && ASYNC_MODE_OUT && POWER_DOWN_OUT
        |-> !TERM_ON_OUT ##[1:5] TERM_ON_OUT) else $error("async on late");
    a_async_off: assert property (
        $fell(TERM_CTRL_PIN_IN) && ASYNC_MODE_OUT && POWER_DOWN_OUT
        |-> ##[1:5] !TERM_ON_OUT) else $error("async off late");
    a_sync_latency: assert property (
        $rose(TERM_CTRL_PIN_IN) && !ASYNC_MODE_OUT && !POWER_DOWN_OUT
        && !TRANSITION_OUT |-> s_sync_on) else $error("sync latency wrong");
    a_entry_async: assert property (
        $fell(CLK_ENABLE_PIN_IN) && !LOOP_FREEZE_SELECT_BIT_IN
        |-> ##[1:10] ASYNC_MODE_OUT) else $error("no async on entry");
    a_frozen_sync: assert property (
        $fell(CLK_ENABLE_PIN_IN) && LOOP_FREEZE_SELECT_BIT_IN
        |-> !ASYNC_MODE_OUT [*8]) else $error("async with bit set");
    a_pd_follow: assert property (
        $fell(CLK_ENABLE_PIN_IN) |-> ##[1:8] POWER_DOWN_OUT)
        else $error("power down not shown");
    a_pd_clear: assert property (
        $rose(CLK_ENABLE_PIN_IN) |-> ##[1:8] !POWER_DOWN_OUT)
        else $error("power down not cleared");
    a_exit_window: assert property (
        $rose(CLK_ENABLE_PIN_IN) && ASYNC_MODE_OUT && POWER_DOWN_OUT
        |-> s_exit_hold) else $error("exit window length wrong");
    a_trans_async: assert property (
        $rose(ASYNC_MODE_OUT) |-> ##[0:2] TRANSITION_OUT)
        else $error("no transition at entry");
endmodule : tamt_term_ctrl_properties

bind tamt_term_ctrl tamt_term_ctrl_properties #(
    .WRITE_LATENCY(WRITE_LATENCY), .LOOP_EXIT(LOOP_EXIT)) i_props (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .LINK_CLK_IN(LINK_CLK_IN),
    .TERM_CTRL_PIN_IN(TERM_CTRL_PIN_IN),
    .CLK_ENABLE_PIN_IN(CLK_ENABLE_PIN_IN), .REFRESH_CMD_IN(REFRESH_CMD_IN),
    .LOOP_FREEZE_SELECT_BIT_IN(LOOP_FREEZE_SELECT_BIT_IN),
    .TERM_ON_OUT(TERM_ON_OUT), .ASYNC_MODE_OUT(ASYNC_MODE_OUT),
    .TRANSITION_OUT(TRANSITION_OUT), .POWER_DOWN_OUT(POWER_DOWN_OUT),
    .LATE_EDGE_OUT(LATE_EDGE_OUT));

// *** dv/tamt_ctrl_model.sv ***
`timescale 1ns/1ns
// ****************************************************************
// memory controller side: termination pin, clock enable, refresh
// ****************************************************************
module tamt_ctrl_model (
    input  wire logic link_clk_in,
    input  wire logic rst_n_in,
    input  wire logic want_term_in,
    input  wire logic want_cke_in,
    input  wire logic want_freeze_in,
    input  wire logic refresh_tgl_in,
    output logic      term_pin_out,
    output logic      cke_pin_out,
    output logic      freeze_bit_out,
    output logic      refresh_out
);
    logic [1:0] settle;
    logic       last_tgl;

    // pins move just after a link edge and only from the fourth edge after
    // reset, so the device's link flops are out of reset first; only the
    // termination, clock-enable, loop freeze select and refresh pins exist,
    // so no read or write can reach the device in power-down
    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settle         <= 2'h0;
            term_pin_out   <= 1'b0;
            cke_pin_out    <= 1'b1;
            freeze_bit_out <= 1'b0;
            refresh_out    <= 1'b0;
            last_tgl       <= refresh_tgl_in;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end else begin
            term_pin_out   <= want_term_in;
            cke_pin_out    <= want_cke_in;
            freeze_bit_out <= want_freeze_in;
            refresh_out    <= refresh_tgl_in != last_tgl; // one-cycle pulse
            last_tgl       <= refresh_tgl_in;
        end
    end
endmodule : tamt_ctrl_model

// *** dv/tamt_term_ctrl_test.sv ***
`timescale 1ns/1ns
module tamt_term_ctrl_test;
    logic clk, link_clk, rst_n, want_term, want_cke, want_freeze, tgl;
    logic term_pin, cke_pin, freeze_bit, refresh;
    logic term_on, async_mode, transition, power_down, late_edge;
    int   mismatches, samples_checked;

    tamt_ctrl_model i_ctrl (.link_clk_in(link_clk), .rst_n_in(rst_n),
        .want_term_in(want_term), .want_cke_in(want_cke),
        .want_freeze_in(want_freeze), .refresh_tgl_in(tgl),
        .term_pin_out(term_pin), .cke_pin_out(cke_pin),
        .freeze_bit_out(freeze_bit), .refresh_out(refresh));
    tamt_term_ctrl i_dut (.CLK_IN(clk), .RST_N_IN(rst_n),
        .LINK_CLK_IN(link_clk), .TERM_CTRL_PIN_IN(term_pin),
        .CLK_ENABLE_PIN_IN(cke_pin), .REFRESH_CMD_IN(refresh),
        .LOOP_FREEZE_SELECT_BIT_IN(freeze_bit), .TERM_ON_OUT(term_on),
        .ASYNC_MODE_OUT(async_mode), .TRANSITION_OUT(transition),
        .POWER_DOWN_OUT(power_down), .LATE_EDGE_OUT(late_edge));

    // ****************************************************************
    // clocks; the link clock has its own phase
    // ****************************************************************
    always #5 clk = ~clk;
    always begin
        #7 link_clk = 1'b1;
        #8 link_clk = 1'b0;
    end

    task automatic check(input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // settle one step past the edge so registered outputs have landed
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    task automatic set_pins(input logic t, input logic c, input logic f);
        @(posedge clk);
        want_term   <= t;
        want_cke    <= c;
        want_freeze <= f;
    endtask : set_pins

    // pin edge two link cycles before clock-enable falls, then async control
    task automatic t_entry_exit;
        set_pins(1'b1, 1'b1, 1'b0);
        wait_clk(2);
        set_pins(1'b1, 1'b0, 1'b0);
        wait_clk(30);
        check(power_down, 1'b1);
        check(async_mode, 1'b1);
        check(transition, 1'b0);
        check(late_edge, 1'b1);
        check(term_on, 1'b1);
        set_pins(1'b0, 1'b0, 1'b0);
        wait_clk(6);
        check(term_on, 1'b0);
        set_pins(1'b1, 1'b0, 1'b0);
        wait_clk(6);
        check(term_on, 1'b1);
        set_pins(1'b0, 1'b1, 1'b0);
        wait_clk(14);
        check(transition, 1'b1);
        wait_clk(30);
        check(async_mode, 1'b0);
        check(late_edge, 1'b0);
    endtask : t_entry_exit

    // refresh in flight when clock-enable drops stretches the entry period
    task automatic t_refresh_entry;
        @(posedge clk);
        want_cke <= 1'b0;
        tgl      <= ~tgl;
        wait_clk(14);
        check(transition, 1'b1);
        wait_clk(20);
        check(transition, 1'b0);
        set_pins(1'b0, 1'b1, 1'b0);
        wait_clk(40);
    endtask : t_refresh_entry

    // refresh holds the entry open so clock-enable rises inside it,
    // then clock-enable falls again before the exit period is over
    task automatic t_short;
        @(posedge clk);
        want_cke <= 1'b0;
        tgl      <= ~tgl;
        wait_clk(6);
        set_pins(1'b0, 1'b1, 1'b0);
        wait_clk(10);
        check(transition, 1'b1);
        check(async_mode, 1'b1);
        set_pins(1'b0, 1'b0, 1'b0);
        wait_clk(30);
        check(async_mode, 1'b1);
        set_pins(1'b0, 1'b1, 1'b0);
        wait_clk(40);
        check(async_mode, 1'b0);
        check(power_down, 1'b0);
    endtask : t_short

    // loop kept running: power-down stays synchronous
    task automatic t_frozen_bit;
        set_pins(1'b0, 1'b1, 1'b1);
        wait_clk(4);
        set_pins(1'b0, 1'b0, 1'b1);
        wait_clk(30);
        check(power_down, 1'b1);
        check(async_mode, 1'b0);
        set_pins(1'b1, 1'b0, 1'b1);
        wait_clk(4);
        check(term_on, 1'b0);
        wait_clk(14);
        check(term_on, 1'b1);
        set_pins(1'b0, 1'b1, 1'b0);
        wait_clk(20);
        check(term_on, 1'b0);
    endtask : t_frozen_bit

    // reset while terminated in power-down clears term_on, async_mode and power_down
    task automatic t_reset_in_pd;
        set_pins(1'b1, 1'b0, 1'b0);
        wait_clk(30);
        check(term_on, 1'b1);
        @(posedge clk);
        rst_n     <= 1'b0;
        want_term <= 1'b0;
        want_cke  <= 1'b1;
        wait_clk(3);
        check(term_on, 1'b0);
        check(async_mode, 1'b0);
        check(power_down, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_clk(10);
        // nothing may wake up on its own after the second release
        check(term_on, 1'b0);
        check(async_mode, 1'b0);
    endtask : t_reset_in_pd

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    initial begin
        {clk, link_clk, rst_n, want_term, want_freeze, tgl} = 6'h00;
        want_cke = 1'b1;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wait_clk(10);
        t_entry_exit();
        t_refresh_entry();
        t_short();
        t_frozen_bit();
        t_reset_in_pd();
        final_report();
    end

    // the whole run needs well under a thousand core cycles
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
endmodule : tamt_term_ctrl_test
